// *** adres_regs.sv ***
// register bank and interrupt logic of the address resolver
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - writing ones to arm register enables interrupts
// - writing ones to disarm register disables interrupts
// - both registers read current interrupt enables
// - status holds last matching key index
// - enable code three on, zero off
// - key count five bits, resets to one
// - start task begins, stop task aborts
// - end flag set on completion, writable
// - time is setup plus per-key time
module adres_regs (
  input  wire logic        MCLK,                // system clock, 200 MHz
  input  wire logic        RSTN,                // asynchronous reset
  input  wire logic        CE,                  // clock enable, low freezes state
  input  wire logic [11:0] ADDR,                // register byte address
  input  wire logic [31:0] WDATA,               // write data
  input  wire logic        WR,                  // write strobe
  input  wire logic        RD,                  // read strobe
  output logic      [31:0] RDATA,               // read data, cycle after RD
  output logic             IRQ,                 // level interrupt
  input  wire logic        HASH_DONE,           // hash unit finished a key
  input  wire logic        HASH_MATCH,          // that key matched
  output logic             HASH_REQ,            // request hash of one key
  output logic      [3:0]  HASH_KEY_INDEX,      // key to hash
  output logic      [31:0] KEY_TABLE_PTR,       // for the fetch path
  output logic      [31:0] CANDIDATE_ADDR_PTR,  // for the fetch path
  output logic      [31:0] TEMP_AREA_PTR        // for the fetch path
);

  // ==========================================================================
  // state of the register bank
  // ==========================================================================
  typedef struct packed {
    logic [2:0]  irq_enable;   // per-event interrupt enables
    logic [2:0]  events;       // event flags
    logic [1:0]  resolver_on;  // enable field, as written
    logic [4:0]  key_count;    // number of keys in the table
    logic [31:0] key_tab_ptr;  // key table address
    logic [31:0] cand_ptr;     // address under test
    logic [31:0] temp_ptr;     // scratch area
    logic [3:0]  last_match;   // index of last matching key
    logic [31:0] rdata;        // registered read answer
    logic        irq;          // registered interrupt level
  } adres_bank_type;

  adres_bank_type bank_reg;   // current state
  adres_bank_type bank_next;  // next state

  // ==========================================================================
  // sequencer hookup
  // ==========================================================================
  logic       begin_task;     // start trigger this cycle
  logic       abort_task;     // stop trigger this cycle
  logic       is_on;          // enable field holds the on code
  logic       eng_hash_req;   // request pulse from the sequencer
  logic [3:0] eng_key_index;  // key under test
  logic       eng_match;      // match pulse
  logic       eng_no_match;   // no-match pulse
  logic       eng_done;       // end pulse
  logic [2:0] hw_events;      // event pulses in flag layout

  // ==========================================================================
  // address decode, used for every register write and task trigger; reads decode ADDR in a case
  // ==========================================================================
  function automatic logic hit_ofs(input logic [11:0] addr, input logic [11:0] ofs);
    hit_ofs = (addr == ofs);
  endfunction : hit_ofs

  // ==========================================================================
  // task triggers
  // ==========================================================================
  // a task is a write with a one in the trigger bit; a zero does nothing
  always_comb begin
    begin_task = WR && hit_ofs(ADDR, adres_pkg::OFS_BEGIN_TASK)
                 && WDATA[adres_pkg::TASK_BIT];
    abort_task = WR && hit_ofs(ADDR, adres_pkg::OFS_ABORT_TASK)
                 && WDATA[adres_pkg::TASK_BIT];
    // only the exact on code counts; any other code leaves the resolver off
    is_on      = (bank_reg.resolver_on == adres_pkg::ON_VALUE);
  end

  // ==========================================================================
  // event pulses gathered into the flag layout
  // ==========================================================================
  always_comb begin
    hw_events                             = 3'h0;
    hw_events[adres_pkg::EV_DONE_BIT]     = eng_done;
    hw_events[adres_pkg::EV_MATCH_BIT]    = eng_match;
    hw_events[adres_pkg::EV_NO_MATCH_BIT] = eng_no_match;
  end

  // ==========================================================================
  // resolution sequencer
  // ==========================================================================
  adres_engine #(
    .IDX_W (adres_pkg::KEY_IDX_W),
    .CNT_W (adres_pkg::KEY_COUNT_W)
  ) u_engine (
    .clk            (MCLK),
    .rst_n          (RSTN),
    .ce             (CE),
    .begin_task     (begin_task),
    .abort_task     (abort_task),
    .resolver_on    (is_on),
    .key_count      (bank_reg.key_count),
    .hash_done      (HASH_DONE),
    .hash_match     (HASH_MATCH),
    .hash_req       (eng_hash_req),
    .key_index      (eng_key_index),
    .match_event    (eng_match),
    .no_match_event (eng_no_match),
    .done_event     (eng_done)
  );

  // ==========================================================================
  // next state of the bank: writes, hardware updates, read answer
  // ==========================================================================
  always_comb begin
    bank_next = bank_reg;

    // ------------------------------------------------------------------------
    // interrupt enables: set and clear through separate words
    // ------------------------------------------------------------------------
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_IRQ_ARM)) begin
      bank_next.irq_enable = bank_reg.irq_enable | WDATA[2:0];
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_IRQ_DISARM)) begin
      bank_next.irq_enable = bank_reg.irq_enable & ~WDATA[2:0];
    end

    // ------------------------------------------------------------------------
    // event flags: software writes the flag bit, a zero clears it
    // ------------------------------------------------------------------------
    // the hardware pulse is applied last, so an event in the clearing cycle
    // is kept rather than lost
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_DONE_EVENT)) begin
      bank_next.events[adres_pkg::EV_DONE_BIT] = WDATA[adres_pkg::EVENT_BIT];
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_MATCH_EVENT)) begin
      bank_next.events[adres_pkg::EV_MATCH_BIT] = WDATA[adres_pkg::EVENT_BIT];
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_NO_MATCH_EVENT)) begin
      bank_next.events[adres_pkg::EV_NO_MATCH_BIT] = WDATA[adres_pkg::EVENT_BIT];
    end
    for (int i = 0; i < adres_pkg::EV_NUM; i++) begin
      if (hw_events[i]) begin
        bank_next.events[i] = 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // configuration words
    // ------------------------------------------------------------------------
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_RESOLVER_ON)) begin
      bank_next.resolver_on = WDATA[adres_pkg::ON_W-1:0];
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_KEY_COUNT)) begin
      // values above sixteen are stored but the walk is clamped to sixteen
      bank_next.key_count = WDATA[adres_pkg::KEY_COUNT_W-1:0];
    end
    // the pointers are only carried to the fetch path; a write during a
    // running resolution takes effect at once, so software must not do it
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_KEY_TABLE_PTR)) begin
      bank_next.key_tab_ptr = WDATA;
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_CAND_ADDR_PTR)) begin
      bank_next.cand_ptr = WDATA;
    end
    if (WR && hit_ofs(ADDR, adres_pkg::OFS_TEMP_AREA_PTR)) begin
      bank_next.temp_ptr = WDATA;
    end

    // ------------------------------------------------------------------------
    // status: index of the key that matched last
    // ------------------------------------------------------------------------
    if (eng_match) begin
      bank_next.last_match = eng_key_index;
    end

    // ------------------------------------------------------------------------
    // read answer, held only for the cycle after the strobe
    // ------------------------------------------------------------------------
    bank_next.rdata = 32'h0000_0000;
    if (RD) begin
      unique case (ADDR)
        adres_pkg::OFS_DONE_EVENT: begin
          bank_next.rdata[adres_pkg::EVENT_BIT] = bank_reg.events[adres_pkg::EV_DONE_BIT];
        end
        adres_pkg::OFS_MATCH_EVENT: begin
          bank_next.rdata[adres_pkg::EVENT_BIT] = bank_reg.events[adres_pkg::EV_MATCH_BIT];
        end
        adres_pkg::OFS_NO_MATCH_EVENT: begin
          bank_next.rdata[adres_pkg::EVENT_BIT] =
            bank_reg.events[adres_pkg::EV_NO_MATCH_BIT];
        end
        adres_pkg::OFS_IRQ_ARM,
        adres_pkg::OFS_IRQ_DISARM: begin
          bank_next.rdata[2:0] = bank_reg.irq_enable;
        end
        adres_pkg::OFS_LAST_MATCH: begin
          bank_next.rdata[3:0] = bank_reg.last_match;
        end
        adres_pkg::OFS_RESOLVER_ON: begin
          bank_next.rdata[adres_pkg::ON_W-1:0] = bank_reg.resolver_on;
        end
        adres_pkg::OFS_KEY_COUNT: begin
          bank_next.rdata[adres_pkg::KEY_COUNT_W-1:0] = bank_reg.key_count;
        end
        adres_pkg::OFS_KEY_TABLE_PTR: begin
          bank_next.rdata = bank_reg.key_tab_ptr;
        end
        adres_pkg::OFS_CAND_ADDR_PTR: begin
          bank_next.rdata = bank_reg.cand_ptr;
        end
        adres_pkg::OFS_TEMP_AREA_PTR: begin
          bank_next.rdata = bank_reg.temp_ptr;
        end
        // tasks and unmapped addresses read as zero
        default: begin
          bank_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // interrupt level from the next flags, so it tracks them with no lag
    // ------------------------------------------------------------------------
    bank_next.irq = |(bank_next.events & bank_next.irq_enable);
  end

  // ==========================================================================
  // bank register, frozen while CE is low
  // ==========================================================================
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      bank_reg <= '{irq_enable:  adres_pkg::RST_IRQ_ENABLE,
                    events:      adres_pkg::RST_EVENTS,
                    resolver_on: adres_pkg::RST_RESOLVER_ON,
                    key_count:   adres_pkg::RST_KEY_COUNT,
                    key_tab_ptr: adres_pkg::RST_POINTER,
                    cand_ptr:    adres_pkg::RST_POINTER,
                    temp_ptr:    adres_pkg::RST_POINTER,
                    last_match:  adres_pkg::RST_LAST_MATCH,
                    rdata:       adres_pkg::RST_RDATA,
                    irq:         1'b0};
    end else if (CE) begin
      bank_reg <= bank_next;
    end
  end

  // ==========================================================================
  // outputs, all taken from flip-flops
  // ==========================================================================
  assign RDATA              = bank_reg.rdata;
  assign IRQ                = bank_reg.irq;
  assign HASH_REQ           = eng_hash_req;
  assign HASH_KEY_INDEX     = eng_key_index;
  assign KEY_TABLE_PTR      = bank_reg.key_tab_ptr;
  assign CANDIDATE_ADDR_PTR = bank_reg.cand_ptr;
  assign TEMP_AREA_PTR      = bank_reg.temp_ptr;

endmodule : adres_regs

`default_nettype wire

// *** adres_pkg.sv ***
// constants and types shared by the address resolver register bank and its sequencer
package adres_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one aligned word each)
  // ==========================================================================
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] OFS_BEGIN_TASK      = 12'h000;
  localparam logic [11:0] OFS_ABORT_TASK      = 12'h008;
  localparam logic [11:0] OFS_DONE_EVENT      = 12'h100;
  localparam logic [11:0] OFS_MATCH_EVENT     = 12'h104;
  localparam logic [11:0] OFS_NO_MATCH_EVENT  = 12'h108;
  localparam logic [11:0] OFS_IRQ_ARM         = 12'h304;
  localparam logic [11:0] OFS_IRQ_DISARM      = 12'h308;
  localparam logic [11:0] OFS_LAST_MATCH      = 12'h400;
  localparam logic [11:0] OFS_RESOLVER_ON     = 12'h500;
  localparam logic [11:0] OFS_KEY_COUNT       = 12'h504;
  localparam logic [11:0] OFS_KEY_TABLE_PTR   = 12'h508;
  localparam logic [11:0] OFS_CAND_ADDR_PTR   = 12'h510;
  localparam logic [11:0] OFS_TEMP_AREA_PTR   = 12'h514;

  // ==========================================================================
  // field positions and widths
  // ==========================================================================
  localparam int unsigned EV_DONE_BIT     = 0;   // end of procedure
  localparam int unsigned EV_MATCH_BIT    = 1;   // address resolved
  localparam int unsigned EV_NO_MATCH_BIT = 2;   // address not resolved
  localparam int unsigned EV_NUM          = 3;
  localparam int unsigned TASK_BIT        = 0;   // trigger bit of a task word
  localparam int unsigned EVENT_BIT       = 0;   // flag bit of an event word
  localparam int unsigned ON_W            = 2;
  localparam int unsigned KEY_COUNT_W     = 5;
  localparam int unsigned KEY_IDX_W       = 4;
  localparam logic [1:0]  ON_VALUE        = 2'h3;  // resolver switched on
  localparam logic [1:0]  OFF_VALUE       = 2'h0;  // resolver switched off
  localparam logic [4:0]  MAX_KEYS        = 5'h10;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [1:0]  RST_RESOLVER_ON = 2'h0;
  localparam logic [4:0]  RST_KEY_COUNT   = 5'h01;
  localparam logic [31:0] RST_POINTER     = 32'h0000_0000;
  localparam logic [2:0]  RST_IRQ_ENABLE  = 3'h0;
  localparam logic [2:0]  RST_EVENTS      = 3'h0;
  localparam logic [3:0]  RST_LAST_MATCH  = 4'h0;
  localparam logic [31:0] RST_RDATA       = 32'h0000_0000;

  // ==========================================================================
  // timing: fixed set-up time ahead of the key walk
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SETUP_TIME_NS = 1000;
  localparam int unsigned SETUP_CYCLES  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CNT_W   = 8;

  // ==========================================================================
  // sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ENG_IDLE   = 3'b000,
    ENG_SETUP  = 3'b001,
    ENG_ISSUE  = 3'b010,
    ENG_WAIT   = 3'b011,
    ENG_FINISH = 3'b100
  } adres_eng_state_type;

endpackage : adres_pkg

// *** adres_engine.sv ***
// resolution sequencer: set-up wait, key walk over the hash unit, result events
`timescale 1ns/100ps
`default_nettype none

module adres_engine #(
  parameter int unsigned IDX_W = adres_pkg::KEY_IDX_W,
  parameter int unsigned CNT_W = adres_pkg::KEY_COUNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             begin_task,     // start pulse from software
  input  wire logic             abort_task,     // stop pulse from software
  input  wire logic             resolver_on,    // enable field holds the on code
  input  wire logic [CNT_W-1:0] key_count,
  input  wire logic             hash_done,      // hash unit finished one key
  input  wire logic             hash_match,     // that key matched
  output logic                  hash_req,       // one-cycle request for a key
  output logic [IDX_W-1:0]      key_index,      // key under test
  output logic                  match_event,    // pulse, key_index is the hit
  output logic                  no_match_event, // pulse, no key matched
  output logic                  done_event      // pulse, procedure complete
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    adres_pkg::adres_eng_state_type  state;
    logic [adres_pkg::SETUP_CNT_W-1:0] cnt;   // set-up countdown
    logic [IDX_W-1:0]                idx;     // key under test
    logic                            req;
    logic                            hit;
    logic                            miss;
    logic                            done;
  } adres_eng_type;

  adres_eng_type eng_reg;
  adres_eng_type eng_next;
  logic [CNT_W-1:0] count_eff;  // key count clamped to the table size
  logic [CNT_W-1:0] idx_plus;   // keys tried so far, this one included

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    eng_next      = eng_reg;
    eng_next.req  = 1'b0;
    eng_next.hit  = 1'b0;
    eng_next.miss = 1'b0;
    eng_next.done = 1'b0;
    // counts above sixteen are unusable, so the walk never leaves the table
    count_eff = (key_count > adres_pkg::MAX_KEYS) ? adres_pkg::MAX_KEYS : key_count;
    idx_plus  = CNT_W'({1'b0, eng_reg.idx}) + CNT_W'(1);
    unique case (eng_reg.state)
      adres_pkg::ENG_IDLE: begin
        if (begin_task && resolver_on) begin
          eng_next.state = adres_pkg::ENG_SETUP;
          eng_next.cnt   = adres_pkg::SETUP_CNT_W'(adres_pkg::SETUP_CYCLES - 1);
          eng_next.idx   = '0;
        end
      end
      adres_pkg::ENG_SETUP: begin
        if (eng_reg.cnt == '0) begin
          if (count_eff == '0) begin  // empty table: nothing can match
            eng_next.miss  = 1'b1;
            eng_next.state = adres_pkg::ENG_FINISH;
          end else begin
            eng_next.state = adres_pkg::ENG_ISSUE;
          end
        end else begin
          eng_next.cnt = eng_reg.cnt - 1'b1;
        end
      end
      adres_pkg::ENG_ISSUE: begin
        eng_next.req   = 1'b1;
        eng_next.state = adres_pkg::ENG_WAIT;
      end
      adres_pkg::ENG_WAIT: begin
        if (hash_done) begin
          if (hash_match) begin
            eng_next.hit   = 1'b1;
            eng_next.state = adres_pkg::ENG_FINISH;
          end else if (idx_plus >= count_eff) begin
            eng_next.miss  = 1'b1;
            eng_next.state = adres_pkg::ENG_FINISH;
          end else begin
            eng_next.idx   = eng_reg.idx + 1'b1;
            eng_next.state = adres_pkg::ENG_ISSUE;
          end
        end
      end
      adres_pkg::ENG_FINISH: begin
        eng_next.done  = 1'b1;  // end follows the result by one cycle
        eng_next.state = adres_pkg::ENG_IDLE;
      end
      default: begin
        eng_next.state = adres_pkg::ENG_IDLE;
      end
    endcase
    // abort or switch-off wins over everything and raises no event
    if ((abort_task || !resolver_on) && eng_reg.state != adres_pkg::ENG_IDLE) begin
      eng_next.state = adres_pkg::ENG_IDLE;
      eng_next.req   = 1'b0;
      eng_next.hit   = 1'b0;
      eng_next.miss  = 1'b0;
      eng_next.done  = 1'b0;
    end
  end

  // ==========================================================================
  // state register, frozen while ce is low
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_reg <= '{state: adres_pkg::ENG_IDLE, cnt: '0, idx: '0,
                   req: 1'b0, hit: 1'b0, miss: 1'b0, done: 1'b0};
    end else if (ce) begin
      eng_reg <= eng_next;
    end
  end

  assign hash_req       = eng_reg.req;
  assign key_index      = eng_reg.idx;
  assign match_event    = eng_reg.hit;
  assign no_match_event = eng_reg.miss;
  assign done_event     = eng_reg.done;

endmodule : adres_engine

`default_nettype wire

// *** adres_regs_asserts.sv ***
// port checker of the resolver register bank
`timescale 1ns/100ps
`default_nettype none
module adres_regs_asserts (
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        HASH_REQ
);
  wire logic rd_ok = RD && CE;  // read taken at this edge
  wire logic wr_ok = WR && CE;  // write taken at this edge
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // ==========================================================================
  // read path: data stand one cycle only, fields keep their widths; hash request lasts one cycle
  AST_RD_IDLE: assert property (!$past(rd_ok) |-> RDATA == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_TASK_RD: assert property (rd_ok && (ADDR == 12'h000 || ADDR == 12'h008)
    |=> RDATA == 32'h0) else $error("task word read not zero");
  AST_IDX_W: assert property (rd_ok && ADDR == 12'h400 |=> RDATA[31:4] == 28'h0)
    else $error("match index wider than four bits");
  AST_ON_RD: assert property (wr_ok && ADDR == 12'h500 && WDATA == 32'h3 ##1 !wr_ok
    ##1 rd_ok && ADDR == 12'h500 |=> RDATA == 32'h3) else $error("enable code lost");
  AST_CNT_RD: assert property (wr_ok && ADDR == 12'h504 && WDATA == 32'h3 ##1 !wr_ok
    ##1 rd_ok && ADDR == 12'h504 |=> RDATA == 32'h3) else $error("key count lost");
  AST_ARM: assert property (wr_ok && ADDR == 12'h304 && WDATA[2:0] == 3'h7 ##1 !wr_ok
    ##1 rd_ok && (ADDR == 12'h304 || ADDR == 12'h308) |=> RDATA[2:0] == 3'h7)
    else $error("arm failed");
  AST_DISARM: assert property (wr_ok && ADDR == 12'h308 && WDATA[2:0] == 3'h7 ##1 !wr_ok
    ##1 rd_ok && ADDR == 12'h304 |=> RDATA[2:0] == 3'h0) else $error("disarm failed");
  AST_REQ_PULSE: assert property (HASH_REQ && CE |=> !HASH_REQ)
    else $error("hash request longer than one cycle");
endmodule : adres_regs_asserts
bind adres_regs adres_regs_asserts u_chk (.MCLK, .RSTN, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .HASH_REQ);
`default_nettype wire

// *** adres_regs_tb_top.sv ***
// self-checking bench of the resolver register bank
`timescale 1ns/100ps
`default_nettype none
module adres_regs_tb_top;
  logic MCLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0, HASH_DONE = 1'b0, HASH_MATCH = 1'b0;
  logic [11:0] ADDR = 12'h0;
  logic [31:0] WDATA = 32'h0, RDATA, KEY_TABLE_PTR, CANDIDATE_ADDR_PTR, TEMP_AREA_PTR;
  logic        IRQ, HASH_REQ, CE = 1'b1;
  logic [3:0]  HASH_KEY_INDEX;
  int          error_cnt = 0, check_count = 0, n = 0;
  logic [11:0] ofs [8] = '{12'h304, 12'h308, 12'h400, 12'h500, 12'h504, 12'h508, 12'h510, 12'h514};
  always #2.5 MCLK = ~MCLK;
  adres_regs dut (.MCLK, .RSTN, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .HASH_DONE,
    .HASH_MATCH, .HASH_REQ, .HASH_KEY_INDEX, .KEY_TABLE_PTR, .CANDIDATE_ADDR_PTR,
    .TEMP_AREA_PTR);
  // ==========================================================================
  // bus tasks: one idle cycle after each access keeps strobes single-driven
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
    @(posedge MCLK);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
    @(posedge MCLK);
  endtask : rd
  task automatic irq_is(input logic e);
    #1 chk({31'h0, IRQ}, {31'h0, e});
    @(posedge MCLK);
  endtask : irq_is
  // answer one hash request, checking which key is asked for
  task automatic serve(input logic [3:0] idx, input logic m);
    n = 0;
    #1;
    while (HASH_REQ !== 1'b1 && n < 400) begin
      @(posedge MCLK);
      #1 n++;
    end
    chk(32'(n < 400), 32'h1);
    chk({28'h0, HASH_KEY_INDEX}, {28'h0, idx});
    @(posedge MCLK);
    HASH_DONE <= 1'b1;
    HASH_MATCH <= m;
    @(posedge MCLK);
    HASH_DONE <= 1'b0;
  endtask : serve
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog: whole sequence needs about 1050 cycles
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  // ==========================================================================
  initial begin
    repeat (8) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    foreach (ofs[i]) rd(ofs[i], {31'h0, ofs[i] == 12'h504});
    rd(12'h000, 32'h0);
    $display("test reset values done");
    wr(12'h304, 32'h5);
    rd(12'h308, 32'h5);
    wr(12'h304, 32'h2);
    wr(12'h308, 32'h1);
    wr(12'h308, 32'h0);
    rd(12'h304, 32'h6);
    wr(12'h304, 32'h7);
    rd(12'h308, 32'h7);
    wr(12'h308, 32'h7);
    rd(12'h304, 32'h0);
    $display("test interrupt enables done");
    for (int i = 5; i < 8; i++) begin
      wr(ofs[i], 32'hc3c3_0000 + i);
      rd(ofs[i], 32'hc3c3_0000 + i);
    end
    chk(KEY_TABLE_PTR, 32'hc3c3_0005);
    chk(CANDIDATE_ADDR_PTR, 32'hc3c3_0006);
    chk(TEMP_AREA_PTR, 32'hc3c3_0007);
    wr(12'h504, 32'hffff_ffff);
    rd(12'h504, 32'h1f);
    wr(12'h504, 32'h3);
    rd(12'h504, 32'h3);
    // a write while the clock enable is low must be lost
    CE <= 1'b0;
    wr(12'h504, 32'h9);
    CE <= 1'b1;
    rd(12'h504, 32'h3);
    wr(12'h500, 32'h3);
    rd(12'h500, 32'h3);
    $display("test configuration done");
    wr(12'h304, 32'h7);
    wr(12'h000, 32'h1);
    serve(4'h0, 1'b0);
    chk(32'(n >= 199 && n <= 210), 32'h1);
    serve(4'h1, 1'b1);
    repeat (3) @(posedge MCLK);
    irq_is(1'b1);
    rd(12'h104, 32'h1);
    rd(12'h108, 32'h0);
    rd(12'h100, 32'h1);
    rd(12'h400, 32'h1);
    wr(12'h100, 32'h0);
    wr(12'h104, 32'h0);
    rd(12'h100, 32'h0);
    irq_is(1'b0);
    $display("test resolved done");
    wr(12'h504, 32'h1);
    wr(12'h000, 32'h1);
    serve(4'h0, 1'b0);
    repeat (3) @(posedge MCLK);
    rd(12'h108, 32'h1);
    rd(12'h400, 32'h1);
    irq_is(1'b1);
    wr(12'h308, 32'h7);
    irq_is(1'b0);
    wr(12'h108, 32'h0);
    wr(12'h100, 32'h0);
    wr(12'h000, 32'h1);
    wr(12'h008, 32'h1);
    // hash answers stand ready, so a walk that was not stopped would end
    HASH_DONE <= 1'b1;
    repeat (250) @(posedge MCLK);
    rd(12'h100, 32'h0);
    wr(12'h500, 32'h0);
    wr(12'h000, 32'h1);
    repeat (250) @(posedge MCLK);
    HASH_DONE <= 1'b0;
    rd(12'h100, 32'h0);
    rd(12'h108, 32'h0);
    $display("test no match and abort done");
    print_verdict();
  end
endmodule : adres_regs_tb_top
`default_nettype wire
